// File: verilog/wor_regs.svh
// Register offsets, field positions, reset values and cycle counts of the option bank
`ifndef WOR_REGS_SVH
`define WOR_REGS_SVH

// Register offsets on the plain register port
`define WOR_ADDR_CFG2       8'h1E
`define WOR_ADDR_CFG1       8'h1F
`define WOR_ADDR_STATUS     8'h20

// Option register 2 fields
`define WOR_C2_OSC_STOP     0
`define WOR_C2_EXT_CLK      1
`define WOR_C2_SLOW_XTAL    2
`define WOR_C2_XTAL         3

// Option register 1 fields
`define WOR_C1_WDOG_DIS     0
`define WOR_C1_STOP_EN      1
`define WOR_C1_SHORT_REC    2
`define WOR_C1_LV_5V        3
`define WOR_C1_LV_PWR_DIS   4
`define WOR_C1_LV_RST_DIS   5
`define WOR_C1_LV_STOP      6
`define WOR_C1_WDOG_RATE    7

// Status register fields
`define WOR_ST_CFG2_LOCK    0
`define WOR_ST_CFG1_LOCK    1
`define WOR_ST_SUPPLY_LOCK  2
`define WOR_ST_STOP         3
`define WOR_ST_RECOVER      4
`define WOR_ST_EXT_STABLE   5

// Reset values
`define WOR_CFG_RESET       8'h00

// Cycle counts, in cycles of the clock that each tick input marks
`define WOR_STAB_XTAL       18'h01000
`define WOR_STAB_SQUARE     18'h00010
`define WOR_REC_SHORT       18'h00020
`define WOR_REC_LONG        18'h01000
`define WOR_WDOG_SHORT      18'h01FF0
`define WOR_WDOG_LONG       32'h0003FFF0

`endif

// File: verilog/wor_pkg.sv
// Types shared by the option bank files
`default_nettype none
package wor_pkg;

    // Stop mode sequencer
    typedef enum logic [1:0] {
        WOR_RUN     = 2'b00,
        WOR_STOP    = 2'b01,
        WOR_RECOVER = 2'b10
    } wor_stop_state_t;

    // Frequency window the clock monitor expects
    typedef enum logic [1:0] {
        WOR_MON_SQUARE    = 2'b00,
        WOR_MON_XTAL_FAST = 2'b01,
        WOR_MON_XTAL_SLOW = 2'b10,
        WOR_MON_OFF       = 2'b11
    } wor_mon_range_t;

endpackage

`default_nettype wire

// File: verilog/wor_tick_counter.sv
// Tick counter that pulses once every limit ticks
`timescale 1ns/1ps
`default_nettype none

module wor_tick_counter (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Control
    input  wire logic        clear,
    input  wire logic        tick,
    input  wire logic [17:0] limit,
    // Result
    output logic             done
);

    logic [17:0] count_q;

    // Terminal tick of the current period
    assign done = tick && !clear && (count_q == (limit - 18'h00001));

    // Count ticks, wrap on done, restart on clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_q <= 18'h00000;
        end else if (clear || done) begin
            count_q <= 18'h00000;
        end else if (tick) begin
            count_q <= count_q + 18'h00001;
        end
    end

endmodule

`default_nettype wire

// File: verilog/wor_option_bank.sv
// Write-once option registers and the clock, stop, watchdog and low-voltage controls they steer
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "wor_regs.svh"

// How it works
// - Crystal enable clear frees oscillator output pin for I/O; set makes it crystal pin while external clock enable is set.
// - Crystal enable picks crystal windows for monitor; clear accepts 60 Hz to 32 MHz.
// - Stabilization divider ends after 4096 ticks with crystal, 16 without.
// - Slow crystal select picks slow crystal and below-307.2 kHz monitor expectation.
// - Slow crystal select matters only while external clock enable is set.
// - Pin use follows external clock enable and crystal enable together.
// - Without run-in-stop, both clock outputs are held low during stop.
// - Watchdog rate select: long period set, 8176 ticks clear; reset clears it.
// - Low-voltage monitor runs in stop only if powered and run-in-stop set.
// - Reset disable blocks the low-voltage monitor's reset request.
// - Power disable powers the low-voltage monitor down.
// - Supply mode picks 5 V or 3 V; only power-on reset clears it.
// - Stop recovery takes 32 oscillator ticks when short, else 4096.
// - Wakeup by a low-voltage reset always takes the long recovery.
// - Stop instruction runs when enabled, otherwise reports an illegal opcode.
// - Watchdog disable stops the watchdog.
// - Watchdog counter requests reset on overflow; software clears it periodically.
// - Each option register takes one write after reset; reset clears all options but supply mode, which only power-on reset clears.
// - Option registers read back at any time.
module wor_option_bank #(
    parameter int WDOG_LONG_TICKS = `WOR_WDOG_LONG
) (
    // Clock and resets
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        sysReset,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    // Clock generator side
    input  wire logic        extClkStart,
    input  wire logic        extClkTick,
    input  wire logic        oscTick,
    output logic             extClkStable,
    output logic             oscInPinGpio,
    output logic             oscOutPinGpio,
    output logic             oscInPinClock,
    output logic             oscOutPinCrystal,
    output logic             extOscEnable,
    output logic             slowCrystalMode,
    output logic             monitorExpectSlow,
    output logic      [1:0]  monitorRange,
    output logic             internalClkRun,
    output logic             externalClkRun,
    // Stop mode
    input  wire logic        stopInstr,
    input  wire logic        wakeEvent,
    output logic             illegalOpcode,
    output logic             stopActive,
    output logic             stopExit,
    // Watchdog
    input  wire logic        watchdogTick,
    input  wire logic        watchdogClear,
    output logic             watchdogEnable,
    output logic             watchdogResetReq,
    // Low-voltage monitor
    input  wire logic        lowVoltTrip,
    output logic             lowVoltPowered,
    output logic             lowVoltResetReq,
    output logic             lowVoltMode5V
);

    logic [7:0]                cfg1_q;
    logic [3:0]                opt1Hi_q;
    logic [2:0]                opt1Lo_q;
    logic                      supply_q;
    logic [7:0]                cfg2_q;
    logic                      cfg1Lock_q;
    logic                      cfg2Lock_q;
    logic                      supplyLock_q;
    logic                      longRec_q;
    wor_pkg::wor_stop_state_t  state_q;
    wor_pkg::wor_stop_state_t  state_d;
    logic                      stable_q;
    logic                      stabDone;
    logic                      recDone;
    logic                      wdogDone;
    logic                      inStop;
    logic                      lvReset;
    logic [17:0]               stabLimit;
    logic [17:0]               recLimit;
    logic [17:0]               wdogLimit;
    logic                      wr1;
    logic                      wr2;

    // Option bit views
    logic crystalEn;
    logic external_clock_enable;
    logic slowSel;
    logic oscRunStop;
    assign crystalEn  = cfg2_q[`WOR_C2_XTAL];
    assign external_clock_enable   = cfg2_q[`WOR_C2_EXT_CLK];
    assign slowSel    = cfg2_q[`WOR_C2_SLOW_XTAL];
    assign oscRunStop = cfg2_q[`WOR_C2_OSC_STOP];

    // First write to each register is taken, later ones dropped
    assign wr2 = regWrite && (regAddr == `WOR_ADDR_CFG2) && !cfg2Lock_q;
    assign wr1 = regWrite && (regAddr == `WOR_ADDR_CFG1) && !cfg1Lock_q;

    // Option register 2 and its lock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg2_q     <= `WOR_CFG_RESET;
            cfg2Lock_q <= 1'b0;
        end else if (sysReset) begin
            cfg2_q     <= `WOR_CFG_RESET;
            cfg2Lock_q <= 1'b0;
        end else if (wr2) begin
            cfg2_q     <= regWrData & 8'h0F;
            cfg2Lock_q <= 1'b1;
        end
    end

    // Option register 1 except the supply mode bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            opt1Hi_q   <= 4'h0;
            opt1Lo_q   <= 3'h0;
            cfg1Lock_q <= 1'b0;
        end else if (sysReset) begin
            opt1Hi_q   <= 4'h0;
            opt1Lo_q   <= 3'h0;
            cfg1Lock_q <= 1'b0;
        end else if (wr1) begin
            opt1Hi_q   <= regWrData[7:4];
            opt1Lo_q   <= regWrData[2:0];
            cfg1Lock_q <= 1'b1;
        end
    end

    // Supply mode bit keeps its own lock, both cleared only at power-on
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            supply_q     <= 1'b0;
            supplyLock_q <= 1'b0;
        end else if (wr1 && !supplyLock_q) begin
            supply_q     <= regWrData[`WOR_C1_LV_5V];
            supplyLock_q <= 1'b1;
        end
    end

    // Register 1 as software sees it, each bit from a single owner
    assign cfg1_q = {opt1Hi_q, supply_q, opt1Lo_q};

    // Read data one cycle after the strobe, zero for unmapped offsets
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (!regRead) begin
            regRdData <= 8'h00;
        end else if (regAddr == `WOR_ADDR_CFG2) begin
            regRdData <= cfg2_q;
        end else if (regAddr == `WOR_ADDR_CFG1) begin
            regRdData <= cfg1_q;
        end else if (regAddr == `WOR_ADDR_STATUS) begin
            regRdData <= {2'b00, stable_q, (state_q == wor_pkg::WOR_RECOVER),
                          inStop, supplyLock_q, cfg1Lock_q, cfg2Lock_q};
        end else begin
            regRdData <= 8'h00;
        end
    end

    // Pin use and external oscillator enable
    assign oscInPinGpio     = !external_clock_enable;
    assign oscInPinClock    = external_clock_enable;
    assign oscOutPinCrystal = external_clock_enable && crystalEn;
    assign oscOutPinGpio    = !oscOutPinCrystal;
    assign extOscEnable     = external_clock_enable;

    // Crystal speed and monitor window
    assign slowCrystalMode   = external_clock_enable && crystalEn && slowSel;
    assign monitorExpectSlow = external_clock_enable && slowSel;
    always_comb begin
        if (!external_clock_enable) begin
            monitorRange = wor_pkg::WOR_MON_OFF;
        end else if (!crystalEn) begin
            monitorRange = wor_pkg::WOR_MON_SQUARE;
        end else if (slowSel) begin
            monitorRange = wor_pkg::WOR_MON_XTAL_SLOW;
        end else begin
            monitorRange = wor_pkg::WOR_MON_XTAL_FAST;
        end
    end

    // External clock stabilization divider
    assign stabLimit = crystalEn ? `WOR_STAB_XTAL : `WOR_STAB_SQUARE;

    wor_tick_counter stabCounter (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (extClkStart || stable_q || !external_clock_enable),
        .tick    (extClkTick),
        .limit   (stabLimit),
        .done    (stabDone)
    );

    // Stable flag, dropped when stabilization restarts, on system reset or with the external clock off
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stable_q <= 1'b0;
        end else if (extClkStart || !external_clock_enable || sysReset) begin
            stable_q <= 1'b0;
        end else if (stabDone) begin
            stable_q <= 1'b1;
        end
    end
    assign extClkStable = stable_q;

    // Clock outputs stop in stop mode unless told to run
    assign inStop         = (state_q == wor_pkg::WOR_STOP);
    assign internalClkRun = !inStop || oscRunStop;
    assign externalClkRun = external_clock_enable && (!inStop || oscRunStop);

    // Low-voltage monitor controls
    assign lowVoltPowered = !cfg1_q[`WOR_C1_LV_PWR_DIS]
                            && (!inStop || cfg1_q[`WOR_C1_LV_STOP]);
    assign lvReset         = lowVoltTrip && lowVoltPowered;
    assign lowVoltResetReq = lvReset && !cfg1_q[`WOR_C1_LV_RST_DIS];
    assign lowVoltMode5V   = cfg1_q[`WOR_C1_LV_5V];

    // Stop mode sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            wor_pkg::WOR_RUN: begin
                if (stopInstr && cfg1_q[`WOR_C1_STOP_EN]) begin
                    state_d = wor_pkg::WOR_STOP;
                end
            end
            wor_pkg::WOR_STOP: begin
                if (wakeEvent || lowVoltResetReq) begin
                    state_d = wor_pkg::WOR_RECOVER;
                end
            end
            wor_pkg::WOR_RECOVER: begin
                if (recDone) begin
                    state_d = wor_pkg::WOR_RUN;
                end
            end
            default: begin
                state_d = wor_pkg::WOR_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= wor_pkg::WOR_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Recovery length chosen at wakeup
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            longRec_q <= 1'b1;
        end else if (inStop && (wakeEvent || lowVoltResetReq)) begin
            longRec_q <= lowVoltResetReq || !cfg1_q[`WOR_C1_SHORT_REC];
        end
    end

    assign recLimit = longRec_q ? `WOR_REC_LONG : `WOR_REC_SHORT;

    wor_tick_counter recCounter (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (state_q != wor_pkg::WOR_RECOVER),
        .tick    (oscTick),
        .limit   (recLimit),
        .done    (recDone)
    );

    assign stopActive = (state_q != wor_pkg::WOR_RUN);
    assign stopExit   = recDone;

    // Disabled stop instruction flags an illegal opcode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            illegalOpcode <= 1'b0;
        end else begin
            illegalOpcode <= stopInstr && (state_q == wor_pkg::WOR_RUN)
                             && !cfg1_q[`WOR_C1_STOP_EN];
        end
    end

    // Watchdog: counts its ticks only in run state, not in stop or recovery, cleared by software or stop entry
    assign watchdogEnable = !cfg1_q[`WOR_C1_WDOG_DIS];
    assign wdogLimit = cfg1_q[`WOR_C1_WDOG_RATE] ? WDOG_LONG_TICKS[17:0]
                                                 : `WOR_WDOG_SHORT;

    wor_tick_counter wdogCounter (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (watchdogClear || !watchdogEnable || sysReset
                  || (state_d == wor_pkg::WOR_STOP)),
        .tick    (watchdogTick && (state_q == wor_pkg::WOR_RUN)),
        .limit   (wdogLimit),
        .done    (wdogDone)
    );

    // Overflow becomes a one-cycle reset request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            watchdogResetReq <= 1'b0;
        end else begin
            watchdogResetReq <= wdogDone;
        end
    end

endmodule

`default_nettype wire

// File: verification/wor_bank_monitor.sv
// Checker tying option bank outputs to their causes
`timescale 1ns/1ps
`default_nettype none
module wor_bank_monitor (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Register port
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    // Pin use and clocks
    input wire logic       oscInPinGpio,
    input wire logic       oscOutPinGpio,
    input wire logic       oscInPinClock,
    input wire logic       oscOutPinCrystal,
    input wire logic       extOscEnable,
    input wire logic       slowCrystalMode,
    input wire logic [1:0] monitorRange,
    input wire logic       internalClkRun,
    input wire logic       externalClkRun,
    // Stop, watchdog, low voltage
    input wire logic       stopInstr,
    input wire logic       illegalOpcode,
    input wire logic       stopActive,
    input wire logic       stopExit,
    input wire logic       watchdogEnable,
    input wire logic       watchdogResetReq,
    input wire logic       lowVoltPowered,
    input wire logic       lowVoltResetReq
);
    // One domain for every check
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Properties
    property p_outPin; oscOutPinGpio != oscOutPinCrystal; endproperty
    property p_pinPair; oscOutPinCrystal |-> oscInPinClock && !oscInPinGpio; endproperty
    property p_slowExt; slowCrystalMode |-> extOscEnable; endproperty
    property p_monOff; (monitorRange == 2'b11) == !extOscEnable; endproperty
    property p_clkRun; !stopActive |-> internalClkRun && (externalClkRun == extOscEnable);
    endproperty
    property p_lvReq; lowVoltResetReq |-> lowVoltPowered; endproperty
    property p_illegal; illegalOpcode |-> $past(stopInstr) && !stopActive; endproperty
    property p_rdData; regRdData != 8'h00 |-> $past(regRead); endproperty
    property p_wdogReq; watchdogResetReq |-> $past(watchdogEnable) ##1 !watchdogResetReq;
    endproperty
    property p_exit; stopExit |=> !stopActive; endproperty

    a_outPin: assert property (p_outPin) else $error("pin use mismatch");
    a_pinPair: assert property (p_pinPair) else $error("pin pair mismatch");
    a_slowExt: assert property (p_slowExt) else $error("slow without ext");
    a_monOff: assert property (p_monOff) else $error("monitor range wrong");
    a_clkRun: assert property (p_clkRun) else $error("clock gated in run");
    a_lvReq: assert property (p_lvReq) else $error("unpowered lv reset");
    a_illegal: assert property (p_illegal) else $error("stray illegal op");
    a_rdData: assert property (p_rdData) else $error("stray read data");
    a_wdogReq: assert property (p_wdogReq) else $error("bad watchdog req");
    a_exit: assert property (p_exit) else $error("stop not left");

    // Main scenarios
    c_exit: cover property (stopExit);
    c_wdog: cover property (watchdogResetReq);
    c_illegal: cover property (illegalOpcode);
endmodule

bind wor_option_bank wor_bank_monitor u_wor_bank_monitor (.ref_clk, .rst, .regRead,
    .regRdData, .oscInPinGpio, .oscOutPinGpio, .oscInPinClock, .oscOutPinCrystal,
    .extOscEnable, .slowCrystalMode, .monitorRange, .internalClkRun, .externalClkRun,
    .stopInstr, .illegalOpcode, .stopActive, .stopExit, .watchdogEnable,
    .watchdogResetReq, .lowVoltPowered, .lowVoltResetReq);
`default_nettype wire

// File: verification/test_wor_option_bank.sv
// Self-checking bench for the write-once option bank
`timescale 1ns/1ps
`default_nettype none
`include "wor_regs.svh"
module test_wor_option_bank;
    localparam int LongTicks = 40;
    // Stimulus; pls bits: stop, wake, osc tick, watchdog tick, system reset,
    // external clock tick, stabilization restart, watchdog service
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] pls = 8'h00;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic       lowVoltTrip = 1'b0;
    // Observed outputs and bench state
    logic [7:0] regRdData;
    logic [1:0] monitorRange;
    logic       oscInPinGpio, oscOutPinGpio, oscInPinClock, oscOutPinCrystal;
    logic       internalClkRun, illegalOpcode, stopActive, watchdogEnable;
    logic       watchdogResetReq, lowVoltResetReq, lowVoltMode5V;
    logic       extClkStable, monitorExpectSlow, lowVoltPowered;
    logic [7:0] rv;
    logic       reqSeen = 1'b0;
    logic       illSeen = 1'b0;
    int         n;
    int         err_count = 0;
    int         num_checks = 0;

    wor_option_bank #(.WDOG_LONG_TICKS(LongTicks)) u_wor_option_bank (
        .ref_clk(ref_clk), .rst(rst), .sysReset(pls[4]), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .extClkStart(pls[6]), .extClkTick(pls[5]), .oscTick(pls[2]),
        .extClkStable(extClkStable),
        .oscInPinGpio(oscInPinGpio), .oscOutPinGpio(oscOutPinGpio),
        .oscInPinClock(oscInPinClock), .oscOutPinCrystal(oscOutPinCrystal),
        .extOscEnable(), .slowCrystalMode(), .monitorExpectSlow(monitorExpectSlow),
        .monitorRange(monitorRange), .internalClkRun(internalClkRun), .externalClkRun(),
        .stopInstr(pls[0]), .wakeEvent(pls[1]), .illegalOpcode(illegalOpcode),
        .stopActive(stopActive), .stopExit(), .watchdogTick(pls[3]),
        .watchdogClear(pls[7]), .watchdogEnable(watchdogEnable),
        .watchdogResetReq(watchdogResetReq), .lowVoltTrip(lowVoltTrip),
        .lowVoltPowered(lowVoltPowered), .lowVoltResetReq(lowVoltResetReq),
        .lowVoltMode5V(lowVoltMode5V));

    // Clock and mid-cycle capture of one-cycle pulses
    always #10 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        if (watchdogResetReq === 1'b1) reqSeen = 1'b1;
        if (illegalOpcode === 1'b1) illSeen = 1'b1;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rv = regRdData;
    endtask
    // One-cycle pulse, then look after one more cycle and the settling half cycle
    task automatic pulse(input logic [7:0] m);
        @(posedge ref_clk);
        pls <= m;
        @(posedge ref_clk);
        pls <= 8'h00;
        @(posedge ref_clk);
        @(negedge ref_clk);
        #1;
    endtask
    // Pulses until watchdog request (w=1) or stop left (w=0), bounded
    task automatic cnt(input logic [7:0] m, input logic w, output int k);
        k = 0;
        reqSeen = 1'b0;
        while (k < 9000 && (w ? !reqSeen : stopActive === 1'b1)) begin
            pulse(m);
            k++;
        end
        if (k == 9000) begin
            err_count++;
            $display("[ERR] t=%0t wait ran out", $time);
            end_of_test();
        end
    endtask

    task automatic t_reset();
        rd(`WOR_ADDR_CFG2);
        cmp(rv, `WOR_CFG_RESET);
        rd(`WOR_ADDR_CFG1);
        cmp(rv, `WOR_CFG_RESET);
        rd(8'h55);
        cmp(rv, 8'h00);
        cmp({oscInPinGpio, oscOutPinGpio, monitorRange}, 4'hF);
        $display("reset test done");
    endtask
    task automatic t_once();
        wr(`WOR_ADDR_CFG2, 8'h0B);
        wr(`WOR_ADDR_CFG2, 8'h04);
        rd(`WOR_ADDR_CFG2);
        cmp(rv, 8'h0B);
        cmp({oscOutPinCrystal, oscInPinClock, oscOutPinGpio}, 3'b110);
        cmp(monitorRange, 2'b01);
        rd(`WOR_ADDR_STATUS);
        cmp(rv[`WOR_ST_CFG2_LOCK], 1'b1);
        $display("write once test done");
    endtask
    task automatic t_cfg1();
        wr(`WOR_ADDR_CFG1, 8'h88);
        rd(`WOR_ADDR_CFG1);
        cmp(rv, 8'h88);
        cmp({lowVoltMode5V, watchdogEnable}, 2'b11);
        illSeen = 1'b0;
        pulse(8'h01);
        cmp({illSeen, stopActive}, 2'b10);
        repeat (30) pulse(8'h08);
        pulse(8'h80);
        cnt(8'h08, 1'b1, n);
        cmp(n, LongTicks);
        $display("option one test done");
    endtask
    task automatic t_sys();
        pulse(8'h10);
        rd(`WOR_ADDR_CFG1);
        cmp(rv, 8'h08);
        rd(`WOR_ADDR_STATUS);
        cmp(rv[1:0], 2'b00);
        wr(`WOR_ADDR_CFG1, 8'h47);
        wr(`WOR_ADDR_CFG2, 8'h02);
        rd(`WOR_ADDR_CFG1);
        cmp(rv, 8'h4F);
        cmp({watchdogEnable, monitorRange}, 3'b000);
        pulse(8'h40);
        repeat (15) pulse(8'h20);
        cmp({extClkStable, monitorExpectSlow}, 2'b00);
        pulse(8'h20);
        cmp(extClkStable, 1'b1);
        $display("system reset test done");
    endtask
    task automatic t_stop();
        pulse(8'h01);
        cmp({stopActive, internalClkRun}, 2'b10);
        pulse(8'h02);
        cnt(8'h04, 1'b0, n);
        cmp(n, `WOR_REC_SHORT);
        pulse(8'h01);
        @(posedge ref_clk);
        lowVoltTrip <= 1'b1;
        #1 cmp(lowVoltResetReq, 1'b1);
        cmp(lowVoltPowered, 1'b1);
        @(posedge ref_clk);
        lowVoltTrip <= 1'b0;
        cnt(8'h04, 1'b0, n);
        cmp(n, `WOR_REC_LONG);
        $display("stop test done");
    endtask

    task automatic t_slow();
        pulse(8'h10);
        wr(`WOR_ADDR_CFG2, 8'h0E);
        rd(`WOR_ADDR_CFG2);
        cmp(rv, 8'h0E);
        cmp({monitorRange, monitorExpectSlow}, 3'b101);
        cnt(8'h08, 1'b1, n);
        cmp(n, `WOR_WDOG_SHORT);
        $display("slow crystal test done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_once();
        t_cfg1();
        t_sys();
        t_stop();
        t_slow();
        end_of_test();
    end
endmodule
`default_nettype wire
